// File: core/epd_bank_arb.sv
// Purpose: per-cycle arbiter between masters that hit the same internal SRAM bank
// Assumes: a stalled master keeps its request until granted
// Notes: priority rotates on every conflict cycle, so no master waits more than N cycles
`timescale 1ns/10ps
module epd_bank_arb #(
  parameter int N = 3,
  parameter int BW = 6
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // requests
  input wire logic [N-1:0] req,
  input wire logic [N-1:0][BW-1:0] bank,
  // grants
  output logic [N-1:0] gnt
);
  localparam int PW = (N > 2) ? $clog2(N) : 1;
  logic [PW-1:0] ptr_reg;

  if (N < 2) begin : g_chk
    $error("bank arbiter needs at least two masters");
  end

  always_comb begin
    int ri;
    int rj;
    ri = 0;
    rj = 0;
    for (int i = 0; i < N; i++) begin
      gnt[i] = req[i];
      ri = (i - int'(ptr_reg) + N) % N;
      for (int j = 0; j < N; j++) begin
        rj = (j - int'(ptr_reg) + N) % N;
        if (j != i && req[j] && bank[j] == bank[i] && rj < ri) begin
          gnt[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= '0;
    end else if (|(req & ~gnt)) begin
      ptr_reg <= (int'(ptr_reg) == N - 1) ? '0 : PW'(int'(ptr_reg) + 1);
    end
  end
endmodule

// File: core/epd_decoder.sv
// Purpose: steers core and DMA accesses to external memory, peripherals and internal memory
// Assumes: one request per master held until ack or err; answers come one cycle after acceptance
// Notes: the MMU table lives here and is written through its own data-bus window
// Summary of operation
// - either core reaches external flash and SRAM through the MMU
// - external accesses are translated to a physical address by MMU table entries
// - physical reach is 16 MB of flash and 8 MB of SRAM
// - data window 0x3F40_0000-0x3F7F_FFFF goes to flash, reads only
// - data window 0x3F80_0000-0x3FBF_FFFF goes to external SRAM, read and write
// - instruction window 0x400C_2000-0x40BF_FFFF goes to flash, reads only
// - peripherals answer at the same address for both cores, except process identity
// - each core reaches only its own process identity unit
// - both cores use the 4 KB window at 0x3FF1_F000, chosen by issuing core
// - SDIO slave answers at three 4 KB windows, same for both cores
// - MMU table is the 16 KB data window 0x3FF1_0000-0x3FF1_3FFF
// - Ethernet MAC is the 8 KB data window 0x3FF6_9000-0x3FF6_AFFF
// - internal ROM, and SRAM without a bank conflict, answer a core access in a single cycle
// - fast RTC memory waits for bus clock, slow for fast clock; DMA uses bus clock
// - cores hitting different 32K SRAM banks proceed together at full speed; DMA still waits for bus clock
`timescale 1ns/10ps
module epd_decoder import epd_pkg::*; #(
  parameter int APB_DIV = APB_DIV_DEF,
  parameter int FAST_DIV = FAST_DIV_DEF
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // master requests
  input wire epd_req_t pro_req,
  input wire epd_req_t app_req,
  input wire epd_req_t dma_req,
  // master responses
  output epd_rsp_t pro_rsp,
  output epd_rsp_t app_rsp,
  output epd_rsp_t dma_rsp
);
  if (APB_DIV < 1 || FAST_DIV < 1 || APB_DIV > 256 || FAST_DIV > 256) begin : g_chk
    $error("clock dividers must be 1 to 256");
  end

  epd_req_t req [NM];
  epd_rsp_t rsp_reg [NM];
  epd_tgt_t tgt_c [NM];
  logic [PHYS_W-1:0] phys_c [NM];
  logic [NM-1:0] live;
  logic [NM-1:0] ready;
  logic [NM-1:0] acc;
  logic [NM-1:0] arb_req;
  logic [NM-1:0] gnt;
  logic [NM-1:0][BANK_W-1:0] bank;
  logic [MMU_ENT_W-1:0] mmu_reg [MMU_ENTRIES];
  logic [7:0] apb_cnt_reg;
  logic [7:0] fast_cnt_reg;
  logic apb_en;
  logic fast_en;

  assign req[MI_PRO] = pro_req;
  assign req[MI_APP] = app_req;
  assign req[MI_DMA] = dma_req;
  assign pro_rsp = rsp_reg[MI_PRO];
  assign app_rsp = rsp_reg[MI_APP];
  assign dma_rsp = rsp_reg[MI_DMA];

  function automatic epd_tgt_t decode(input epd_req_t r, input int m);
    logic [31:0] a;
    a = r.addr;
    decode = TGT_NONE;
    if (m == MI_DMA) begin
      if (!r.ibus && epd_in(a, DISRAM_LO, DISRAM_HI)) decode = TGT_SRAM;
    end else if (r.ibus) begin
      if (epd_in(a, IROM0_LO, IROM0_HI) && !r.write) decode = TGT_ROM;
      else if (epd_in(a, IISRAM_LO, IISRAM_HI)) decode = TGT_SRAM;
      else if (epd_in(a, IRTCF_LO, IRTCF_HI) && m == MI_PRO) decode = TGT_RTC_FAST;
      else if (epd_in(a, IFLASH_LO, IFLASH_HI) && !r.write) decode = TGT_EXT_FLASH;
      else if (epd_in(a, RTCS_LO, RTCS_HI)) decode = TGT_RTC_SLOW;
    end else begin
      if (epd_in(a, DFLASH_LO, DFLASH_HI)) decode = r.write ? TGT_NONE : TGT_EXT_FLASH;
      else if (epd_in(a, DSRAM_LO, DSRAM_HI)) decode = TGT_EXT_SRAM;
      else if (epd_in(a, MMU_LO, MMU_HI)) decode = TGT_MMU;
      else if ((a & WIN4K_MASK) == PID_BASE) decode = (m == MI_PRO) ? TGT_PID_PRO : TGT_PID_APP;
      else if ((a & WIN4K_MASK) == SDIO_BASE0 || (a & WIN4K_MASK) == SDIO_BASE1 ||
               (a & WIN4K_MASK) == SDIO_BASE2) decode = TGT_SDIO;
      else if (epd_in(a, ETHERNET_MAC_LO, ETHERNET_MAC_HI)) decode = TGT_ETHERNET_MAC;
      else if (epd_in(a, PERIPH_LO, PERIPH_HI) && PERIPH_PAGES[a[18:12]]) decode = TGT_PERIPH;
      else if (epd_in(a, ROM1_LO, ROM1_HI) && !r.write) decode = TGT_ROM;
      else if (epd_in(a, DRTCF_LO, DRTCF_HI) && m == MI_PRO) decode = TGT_RTC_FAST;
      else if (epd_in(a, DISRAM_LO, DISRAM_HI)) decode = TGT_SRAM;
      else if (epd_in(a, RTCS_LO, RTCS_HI)) decode = TGT_RTC_SLOW;
    end
  endfunction

  // bus clock and fast clock as enables; the RTC memories and DMA move only on them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      apb_cnt_reg <= 8'h00;
    end else begin
      apb_cnt_reg <= apb_en ? 8'h00 : apb_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fast_cnt_reg <= 8'h00;
    end else begin
      fast_cnt_reg <= fast_en ? 8'h00 : fast_cnt_reg + 8'h01;
    end
  end

  assign apb_en = (apb_cnt_reg == 8'(APB_DIV - 1));
  assign fast_en = (fast_cnt_reg == 8'(FAST_DIV - 1));

  always_comb begin
    logic [MMU_IDX_W-1:0] idx;
    idx = '0;
    for (int i = 0; i < NM; i++) begin
      tgt_c[i] = decode(req[i], i);
      // a master's own answer cycle is skipped so a held request is not taken twice
      live[i] = req[i].valid && !rsp_reg[i].ack && !rsp_reg[i].err;
      bank[i] = {req[i].ibus, req[i].addr[BANK_LSB +: BANK_W-1]};
      arb_req[i] = live[i] && tgt_c[i] == TGT_SRAM && (i != MI_DMA || apb_en);
      idx = {req[i].ibus ? MMU_RGN_IFLASH : (tgt_c[i] == TGT_EXT_SRAM ? MMU_RGN_DSRAM : MMU_RGN_DFLASH),
             req[i].addr[EXT_PAGE_LSB +: MMU_IDX_W-2]};
      case (tgt_c[i])
        TGT_EXT_FLASH: phys_c[i] = {mmu_reg[idx], req[i].addr[EXT_PAGE_LSB-1:0]};
        TGT_EXT_SRAM: phys_c[i] = {1'b0, mmu_reg[idx][MMU_ENT_W-2:0], req[i].addr[EXT_PAGE_LSB-1:0]};
        default: phys_c[i] = req[i].addr[PHYS_W-1:0];
      endcase
      case (tgt_c[i])
        TGT_SRAM: ready[i] = gnt[i];
        TGT_RTC_FAST: ready[i] = apb_en;
        TGT_RTC_SLOW: ready[i] = fast_en;
        default: ready[i] = 1'b1;
      endcase
      acc[i] = live[i] && ready[i];
    end
  end

  epd_bank_arb #(.N(NM), .BW(BANK_W)) u_arb (
    .mclk(mclk),
    .resetn(resetn),
    .req(arb_req),
    .bank(bank),
    .gnt(gnt)
  );

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NM; i++) begin
        rsp_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NM; i++) begin
        rsp_reg[i].ack <= acc[i] && tgt_c[i] != TGT_NONE;
        rsp_reg[i].err <= acc[i] && tgt_c[i] == TGT_NONE;
        rsp_reg[i].stall <= live[i] && !ready[i];
        rsp_reg[i].tgt <= acc[i] ? tgt_c[i] : TGT_NONE;
        rsp_reg[i].phys <= acc[i] ? phys_c[i] : '0;
      end
    end
  end

  // table starts as an identity map; the protocol core wins a same-cycle write
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int e = 0; e < MMU_ENTRIES; e++) begin
        mmu_reg[e] <= MMU_ENT_W'(e);
      end
    end else begin
      for (int i = MI_APP; i >= MI_PRO; i--) begin
        if (acc[i] && req[i].write && tgt_c[i] == TGT_MMU) begin
          mmu_reg[req[i].addr[2 +: MMU_IDX_W]] <= req[i].wdata;
        end
      end
    end
  end

  flash_read_only_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && !pro_req.ibus && pro_req.write && epd_in(pro_req.addr, DFLASH_LO, DFLASH_HI)
    |=> pro_rsp.err && pro_rsp.tgt == TGT_NONE) else $error("flash data write not refused");
  ext_sram_rw_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[1] && !app_req.ibus && epd_in(app_req.addr, DSRAM_LO, DSRAM_HI)
    |=> app_rsp.ack && app_rsp.tgt == TGT_EXT_SRAM) else $error("external sram access not routed");
  ibus_flash_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && pro_req.ibus && !pro_req.write && epd_in(pro_req.addr, IFLASH_LO, IFLASH_HI)
    |=> pro_rsp.ack && pro_rsp.tgt == TGT_EXT_FLASH) else $error("instruction flash read not routed");
  ext_offset_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && !pro_req.ibus && !pro_req.write && epd_in(pro_req.addr, DFLASH_LO, DFLASH_HI)
    |=> pro_rsp.phys[15:0] == $past(pro_req.addr[15:0])) else $error("page offset lost in translation");
  sram_reach_a: assert property (@(posedge mclk) disable iff (!resetn)
    app_rsp.ack && app_rsp.tgt == TGT_EXT_SRAM |-> !app_rsp.phys[23]) else $error("sram beyond 8 MB");
  pid_private_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[1] && !app_req.ibus && (app_req.addr & WIN4K_MASK) == PID_BASE
    |=> app_rsp.tgt == TGT_PID_APP) else $error("application core reached wrong identity unit");
  pid_shared_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && !pro_req.ibus && (pro_req.addr & WIN4K_MASK) == PID_BASE
    |=> pro_rsp.tgt == TGT_PID_PRO) else $error("protocol core reached wrong identity unit");
  sdio_parts_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[1] && !app_req.ibus && (app_req.addr & WIN4K_MASK) == SDIO_BASE2
    |=> app_rsp.ack && app_rsp.tgt == TGT_SDIO) else $error("sdio part not decoded");
  ethernet_mac_window_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && !pro_req.ibus && (pro_req.addr & WIN4K_MASK) == 32'h3FF6_A000
    |=> pro_rsp.tgt == TGT_ETHERNET_MAC) else $error("second mac page not decoded");
  reserved_gap_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && !pro_req.ibus && epd_in(pro_req.addr, 32'h3FF2_0000, 32'h3FF3_FFFF)
    |=> pro_rsp.err && !pro_rsp.ack) else $error("reserved access not refused");
  sram_single_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && tgt_c[0] == TGT_SRAM && !live[1] && !live[2] |=> pro_rsp.ack) else $error("sram not single cycle");
  rtc_slow_wait_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && tgt_c[0] == TGT_RTC_SLOW && !fast_en |=> pro_rsp.stall && !pro_rsp.ack)
    else $error("slow memory taken off its clock");
  bank_parallel_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && live[1] && tgt_c[0] == TGT_SRAM && tgt_c[1] == TGT_SRAM && bank[0] != bank[1]
    && !(arb_req[2] && (bank[2] == bank[0] || bank[2] == bank[1])) |=> pro_rsp.ack && app_rsp.ack)
    else $error("banks not parallel");
  bank_conflict_a: assert property (@(posedge mclk) disable iff (!resetn)
    live[0] && live[1] && tgt_c[0] == TGT_SRAM && tgt_c[1] == TGT_SRAM && bank[0] == bank[1]
    |=> (pro_rsp.ack != app_rsp.ack) || (dma_rsp.ack && !pro_rsp.ack)) else $error("same bank not arbitrated");

  cov_conflict_c: cover property (@(posedge mclk) disable iff (!resetn) pro_rsp.stall ##1 pro_rsp.ack);
  cov_flash_c: cover property (@(posedge mclk) disable iff (!resetn) app_rsp.ack && app_rsp.tgt == TGT_EXT_FLASH);
  cov_pid_c: cover property (@(posedge mclk) disable iff (!resetn) pro_rsp.tgt == TGT_PID_PRO ##[1:20] app_rsp.tgt == TGT_PID_APP);
  cov_dma_c: cover property (@(posedge mclk) disable iff (!resetn) dma_rsp.ack && dma_rsp.tgt == TGT_SRAM);
endmodule

// File: core/epd_pkg.sv
// Purpose: shared constants and types of the external and peripheral address decoder
// Assumes: 32-bit byte addresses on every master port
// Notes: peripheral pages are 4 KB; external memory pages are 64 KB
package epd_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int NM = 3;
  localparam int MI_PRO = 0;
  localparam int MI_APP = 1;
  localparam int MI_DMA = 2;
  // external memory windows
  localparam logic [31:0] DFLASH_LO = 32'h3F40_0000;
  localparam logic [31:0] DFLASH_HI = 32'h3F7F_FFFF;
  localparam logic [31:0] DSRAM_LO = 32'h3F80_0000;
  localparam logic [31:0] DSRAM_HI = 32'h3FBF_FFFF;
  localparam logic [31:0] IFLASH_LO = 32'h400C_2000;
  localparam logic [31:0] IFLASH_HI = 32'h40BF_FFFF;
  // peripheral windows
  localparam logic [31:0] PERIPH_LO = 32'h3FF0_0000;
  localparam logic [31:0] PERIPH_HI = 32'h3FF7_FFFF;
  localparam logic [31:0] MMU_LO = 32'h3FF1_0000;
  localparam logic [31:0] MMU_HI = 32'h3FF1_3FFF;
  localparam logic [31:0] PID_BASE = 32'h3FF1_F000;
  localparam logic [31:0] SDIO_BASE0 = 32'h3FF4_B000;
  localparam logic [31:0] SDIO_BASE1 = 32'h3FF5_5000;
  localparam logic [31:0] SDIO_BASE2 = 32'h3FF5_8000;
  localparam logic [31:0] ETHERNET_MAC_LO = 32'h3FF6_9000;
  localparam logic [31:0] ETHERNET_MAC_HI = 32'h3FF6_AFFF;
  localparam logic [31:0] WIN4K_MASK = 32'hFFFF_F000;
  // one bit per 4 KB page of the peripheral area, set where a peripheral answers
  localparam logic [127:0] PERIPH_PAGES = 128'h0021F7F1_CFF99B1D_00000000_800F001F;
  // internal memories
  localparam logic [31:0] ROM1_LO = 32'h3FF9_0000;
  localparam logic [31:0] ROM1_HI = 32'h3FF9_FFFF;
  localparam logic [31:0] DISRAM_LO = 32'h3FFA_E000;
  localparam logic [31:0] DISRAM_HI = 32'h3FFF_FFFF;
  localparam logic [31:0] IROM0_LO = 32'h4000_0000;
  localparam logic [31:0] IROM0_HI = 32'h4005_FFFF;
  localparam logic [31:0] IISRAM_LO = 32'h4007_0000;
  localparam logic [31:0] IISRAM_HI = 32'h400B_FFFF;
  localparam logic [31:0] DRTCF_LO = 32'h3FF8_0000;
  localparam logic [31:0] DRTCF_HI = 32'h3FF8_1FFF;
  localparam logic [31:0] IRTCF_LO = 32'h400C_0000;
  localparam logic [31:0] IRTCF_HI = 32'h400C_1FFF;
  localparam logic [31:0] RTCS_LO = 32'h5000_0000;
  localparam logic [31:0] RTCS_HI = 32'h5000_1FFF;
  // mapping and banking
  localparam int EXT_PAGE_LSB = 16;
  localparam int PHYS_W = 24;
  localparam int MMU_ENT_W = 8;
  localparam int MMU_IDX_W = 10;
  localparam int MMU_ENTRIES = 1024;
  localparam logic [1:0] MMU_RGN_DFLASH = 2'h0;
  localparam logic [1:0] MMU_RGN_DSRAM = 2'h1;
  localparam logic [1:0] MMU_RGN_IFLASH = 2'h2;
  localparam int BANK_LSB = 15;
  localparam int BANK_W = 6;
  localparam int APB_DIV_DEF = 2;
  localparam int FAST_DIV_DEF = 4;

  typedef enum logic [3:0] {
    TGT_NONE = 4'h0, TGT_EXT_FLASH = 4'h1, TGT_EXT_SRAM = 4'h2, TGT_MMU = 4'h3,
    TGT_PID_PRO = 4'h4, TGT_PID_APP = 4'h5, TGT_SDIO = 4'h6, TGT_ETHERNET_MAC = 4'h7,
    TGT_PERIPH = 4'h8, TGT_ROM = 4'h9, TGT_SRAM = 4'hA, TGT_RTC_FAST = 4'hB,
    TGT_RTC_SLOW = 4'hC
  } epd_tgt_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic ibus;
    logic [31:0] addr;
    logic [7:0] wdata;
  } epd_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic stall;
    epd_tgt_t tgt;
    logic [PHYS_W-1:0] phys;
  } epd_rsp_t;

  function automatic logic epd_in(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction
endpackage

// File: verification/epd_master_model.sv
// Purpose: model of one bus master, a core or the DMA, facing the decoder
// Assumes: the bench raises start only while busy is low
// Notes: a released address shows its inverse so a stale value never matches by luck
`timescale 1ns/10ps
module epd_master_model import epd_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // command from the bench
  input wire logic start,
  input wire epd_req_t cmd,
  // decoder side
  output epd_req_t req,
  input wire epd_rsp_t rsp,
  // result of the last access
  output logic busy,
  output epd_rsp_t last,
  output logic [7:0] cyc
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      req <= '0;
      busy <= 1'b0;
      last <= '0;
      cyc <= 8'h00;
    end else if (!busy && start) begin
      req <= cmd;
      busy <= 1'b1;
      cyc <= 8'h00;
    end else if (busy && (rsp.ack || rsp.err)) begin
      // held unchanged through any stall, dropped right after the answer
      req.valid <= 1'b0;
      req.addr <= ~req.addr;
      busy <= 1'b0;
      last <= rsp;
    end else if (busy) begin
      cyc <= cyc + 8'h01;
    end
  end
endmodule

// File: verification/external_and_peripheral_address_decoder_bench.sv
// Purpose: self-checking bench of the address decoder with three master models
// Assumes: identity MMU table after reset, default clock-enable dividers
// Notes: instruction-bus flag is taken from address bit 30
`timescale 1ns/10ps
module external_and_peripheral_address_decoder_bench import epd_pkg::*; ();
  localparam int APB = 2;
  localparam int FAST = 4;
  localparam logic [31:0] REFUSE = 32'hFFFF_FFFF;
  logic mclk = 1'b0;
  logic resetn;
  logic [2:0] start = 3'h0;
  logic [2:0] busy;
  epd_req_t cmd [3];
  epd_req_t req [3];
  epd_rsp_t rsp [3];
  epd_rsp_t last [3];
  logic [7:0] cyc [3];
  logic [7:0] stl [3];
  int miscompares = 0;
  int comparisons = 0;

  always #20 mclk = ~mclk;

  for (genvar g = 0; g < 3; g++) begin : gm
    epd_master_model u_m (.mclk(mclk), .resetn(resetn), .start(start[g]), .cmd(cmd[g]), .req(req[g]),
      .rsp(rsp[g]), .busy(busy[g]), .last(last[g]), .cyc(cyc[g]));
  end

  epd_decoder #(.APB_DIV(APB), .FAST_DIV(FAST)) DUT (.mclk(mclk), .resetn(resetn),
    .pro_req(req[MI_PRO]), .app_req(req[MI_APP]), .dma_req(req[MI_DMA]),
    .pro_rsp(rsp[MI_PRO]), .app_rsp(rsp[MI_APP]), .dma_rsp(rsp[MI_DMA]));

  task automatic tally_and_finish();
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] ok(input epd_tgt_t t, input logic [23:0] p);
    return {4'b0010, t, p};
  endfunction

  // launch the masters in m together and wait, bounded, until all are answered
  task automatic run(input logic [2:0] m);
    stl = '{8'h00, 8'h00, 8'h00};
    start = m;
    @(posedge mclk);
    #1;
    start = 3'h0;
    for (int n = 0; n < 40 && (busy & m) != 3'h0; n++) begin
      @(posedge mclk);
      #1;
      // stall lags each waiting cycle by one, so it should count cyc - 1
      for (int g = 0; g < 3; g++) stl[g] = stl[g] + 8'(rsp[g].stall);
    end
    if ((busy & m) != 3'h0) begin
      miscompares++;
      $display("wrong value at %0t: access never answered", $time);
    end
  endtask

  task automatic set(input int i, input logic [31:0] a, input logic wr, input logic [7:0] wd);
    cmd[i] = '{valid: 1'b1, write: wr, ibus: a[30], addr: a, wdata: wd};
  endtask

  task automatic acc(input int i, input logic [31:0] a, input logic wr, input logic [7:0] wd,
                     input logic [31:0] exp);
    set(i, a, wr, wd);
    run(3'(1 << i));
    if (exp === REFUSE) chk({30'h0, last[i].ack, last[i].err}, 32'h1);
    else chk({4'h0, last[i].tgt, last[i].phys} | {2'b00, last[i].ack, last[i].err, 28'h0}, exp);
  endtask

  task automatic lat(input int i, input int lo, input int hi);
    chk({31'h0, cyc[i] >= lo && cyc[i] <= hi}, 32'h1);
    chk({24'h0, stl[i]}, {24'h0, cyc[i] - 8'h01});
  endtask

  task automatic test_ext_flash();
    acc(MI_PRO, 32'h3F40_1234, 1'b0, 8'h00, ok(TGT_EXT_FLASH, 24'h40_1234));
    acc(MI_APP, 32'h3F7F_FFFF, 1'b0, 8'h00, ok(TGT_EXT_FLASH, 24'h7F_FFFF));
    acc(MI_PRO, 32'h3F40_0000, 1'b1, 8'h5A, REFUSE);
    acc(MI_APP, 32'h400C_2000, 1'b0, 8'h00, ok(TGT_EXT_FLASH, 24'h0C_2000));
    acc(MI_PRO, 32'h40BF_FFFF, 1'b0, 8'h00, ok(TGT_EXT_FLASH, 24'hBF_FFFF));
    acc(MI_APP, 32'h400C_3000, 1'b1, 8'h00, REFUSE);
    acc(MI_PRO, 32'h40C0_0000, 1'b0, 8'h00, REFUSE);
  endtask

  task automatic test_ext_sram();
    acc(MI_PRO, 32'h3F80_0010, 1'b1, 8'h33, ok(TGT_EXT_SRAM, 24'h00_0010));
    acc(MI_APP, 32'h3FBF_FFFF, 1'b0, 8'h00, ok(TGT_EXT_SRAM, 24'h3F_FFFF));
  endtask

  // entry 0x045 maps data flash page 0x45; the reserved write aliases the same entry index
  task automatic test_mmu();
    acc(MI_PRO, 32'h3FF1_0114, 1'b1, 8'hFF, ok(TGT_MMU, 24'hF1_0114));
    acc(MI_APP, 32'h3F45_0020, 1'b0, 8'h00, ok(TGT_EXT_FLASH, 24'hFF_0020));
    acc(MI_APP, 32'h3FF1_0604, 1'b1, 8'hFF, ok(TGT_MMU, 24'hF1_0604));
    acc(MI_PRO, 32'h3F81_0000, 1'b0, 8'h00, ok(TGT_EXT_SRAM, 24'h7F_0000));
    acc(MI_APP, 32'h3FF1_4114, 1'b1, 8'h12, REFUSE);
    acc(MI_PRO, 32'h3F45_0000, 1'b1, 8'h34, REFUSE);
    acc(MI_PRO, 32'h3F45_0020, 1'b0, 8'h00, ok(TGT_EXT_FLASH, 24'hFF_0020));
    acc(MI_APP, 32'h3FF1_3FFF, 1'b0, 8'h00, ok(TGT_MMU, 24'hF1_3FFF));
    acc(MI_PRO, 32'h3FF0_FFFC, 1'b0, 8'h00, REFUSE);
    acc(MI_PRO, 32'h3FF0_A000, 1'b0, 8'h00, REFUSE);
    acc(MI_PRO, 32'h3FF3_0000, 1'b1, 8'h00, REFUSE);
  endtask

  task automatic test_pid();
    for (int i = 0; i < 2; i++) begin
      acc(i, 32'h3FF1_F000, 1'(i), 8'h00, ok(i == 0 ? TGT_PID_PRO : TGT_PID_APP, 24'hF1_F000));
      acc(i, 32'h3FF1_FFFF, 1'b0, 8'h00, ok(i == 0 ? TGT_PID_PRO : TGT_PID_APP, 24'hF1_FFFF));
      acc(i, 32'h3FF4_0000, 1'b0, 8'h00, ok(TGT_PERIPH, 24'hF4_0000));
      acc(i, 32'h3FF7_5FFF, 1'b1, 8'h00, ok(TGT_PERIPH, 24'hF7_5FFF));
      acc(i, 32'h3FF4_1000, 1'b0, 8'h00, REFUSE);
    end
    acc(MI_APP, 32'h3FF1_EFFC, 1'b0, 8'h00, REFUSE);
  endtask

  task automatic test_sdio();
    logic [31:0] b [3];
    logic [31:0] a;
    b = '{SDIO_BASE0, SDIO_BASE1, SDIO_BASE2};
    for (int k = 0; k < 3; k++) begin
      for (int i = 0; i < 2; i++) begin
        a = b[k] + (i == 0 ? 32'h0 : 32'hFFF);
        acc(i, a, 1'(i), 8'h00, ok(TGT_SDIO, a[23:0]));
      end
    end
    acc(MI_PRO, 32'h3FF4_AFFF, 1'b0, 8'h00, REFUSE);
    acc(MI_APP, 32'h3FF5_9000, 1'b0, 8'h00, ok(TGT_PERIPH, 24'hF5_9000));
  endtask

  task automatic test_ethernet_mac();
    acc(MI_APP, 32'h3FF6_9000, 1'b1, 8'h00, ok(TGT_ETHERNET_MAC, 24'hF6_9000));
    acc(MI_PRO, 32'h3FF6_AFFF, 1'b0, 8'h00, ok(TGT_ETHERNET_MAC, 24'hF6_AFFF));
    acc(MI_APP, 32'h3FF6_8FFF, 1'b0, 8'h00, ok(TGT_PERIPH, 24'hF6_8FFF));
    acc(MI_PRO, 32'h3FF6_B000, 1'b0, 8'h00, REFUSE);
  endtask

  task automatic test_latency();
    acc(MI_PRO, 32'h3FF9_0000, 1'b0, 8'h00, ok(TGT_ROM, 24'hF9_0000));
    lat(MI_PRO, 1, 1);
    acc(MI_PRO, 32'h4008_0000, 1'b1, 8'h00, ok(TGT_SRAM, 24'h08_0000));
    lat(MI_PRO, 1, 1);
    acc(MI_PRO, 32'h3FF8_0000, 1'b1, 8'h00, ok(TGT_RTC_FAST, 24'hF8_0000));
    lat(MI_PRO, 1, 1 + APB);
    acc(MI_APP, 32'h3FF8_0000, 1'b0, 8'h00, REFUSE);
    for (int n = 0; n < 3; n++) begin
      acc(n % 2, 32'h5000_1FFF, 1'b0, 8'h00, ok(TGT_RTC_SLOW, 24'h00_1FFF));
      lat(n % 2, 1, 1 + FAST);
    end
    acc(MI_DMA, 32'h3FFA_E000, 1'b1, 8'h00, ok(TGT_SRAM, 24'hFA_E000));
    lat(MI_DMA, 1, 1 + APB);
  endtask

  task automatic test_banks();
    set(MI_PRO, 32'h3FFE_0000, 1'b0, 8'h00);
    set(MI_APP, 32'h3FFF_0000, 1'b1, 8'h00);
    set(MI_DMA, 32'h3FFB_0000, 1'b1, 8'h00);
    run(3'h7);
    lat(MI_PRO, 1, 1);
    lat(MI_APP, 1, 1);
    lat(MI_DMA, 1, 1 + APB);
    set(MI_PRO, 32'h3FFE_0000, 1'b1, 8'h00);
    set(MI_APP, 32'h3FFE_0004, 1'b0, 8'h00);
    run(3'h3);
    chk({4'h0, last[0].tgt, 4'h0, last[1].tgt, 16'h0}, {4'h0, TGT_SRAM, 4'h0, TGT_SRAM, 16'h0});
    chk({24'h0, cyc[0] + cyc[1]}, 32'h3);
    set(MI_DMA, 32'h3FFE_0008, 1'b0, 8'h00);
    run(3'h7);
    for (int i = 0; i < 3; i++) lat(i, 1, 3 + APB);
  endtask

  initial begin
    resetn = 1'b0;
    for (int i = 0; i < 3; i++) cmd[i] = '0;
    repeat (5) @(posedge mclk);
    #1;
    resetn = 1'b1;
    test_ext_flash();
    test_ext_sram();
    test_mmu();
    test_pid();
    test_sdio();
    test_ethernet_mac();
    test_latency();
    test_banks();
    tally_and_finish();
  end

  // about 60 accesses of a few cycles each; this leaves a wide margin
  initial begin
    #(40 * 4000);
    miscompares++;
    tally_and_finish();
  end
endmodule
